/* slpa_alu_regs.vh */
/*
 Operation codes, field positions and cycle counts for the shift, logic
 and pointer datapath. Assumes inclusion by bare name from the datapath.
*/
`ifndef SLPA_ALU_REGS_VH
`define SLPA_ALU_REGS_VH

// Operation codes on op_in
`define SLPA_OP_AND          5'h00
`define SLPA_OP_OR           5'h01
`define SLPA_OP_XOR          5'h02
`define SLPA_OP_INVERT       5'h03
`define SLPA_OP_AND_IMM      5'h04
`define SLPA_OP_OR_IMM       5'h05
`define SLPA_OP_XOR_IMM      5'h06
`define SLPA_OP_ASHL_ONE     5'h07
`define SLPA_OP_ASHL_VAR     5'h08
`define SLPA_OP_ASHR_ONE     5'h09
`define SLPA_OP_ASHR_VAR     5'h0A
`define SLPA_OP_ASHR_ACC     5'h0B
`define SLPA_OP_LSHL_ONE     5'h0C
`define SLPA_OP_LSHL_VAR     5'h0D
`define SLPA_OP_LSHR_ONE     5'h0E
`define SLPA_OP_LSHR_VAR     5'h0F
`define SLPA_OP_LSHR_ACC     5'h10
`define SLPA_OP_ROL_CARRY    5'h11
`define SLPA_OP_ROR_CARRY    5'h12
`define SLPA_OP_ALIGN_STEP   5'h13
`define SLPA_OP_PTR_INC      5'h14
`define SLPA_OP_PTR_DEC      5'h15
`define SLPA_OP_PTR_INDEX    5'h16
`define SLPA_OP_PTR_TWO_OFS  5'h17
`define SLPA_OP_PTR_SP_ADJ   5'h18
`define SLPA_OP_PTR_LONG_OFS 5'h19
`define SLPA_OP_TEST_DEC     5'h1A

// Accumulator and operand field positions
`define SLPA_EXT_MSB         35
`define SLPA_EXT_LSB         32
`define SLPA_MSP_MSB         31
`define SLPA_MSP_LSB         16
`define SLPA_CNT_MSB         3
`define SLPA_OFS6_MSB        5

// Cycle counts per instruction
`define SLPA_CYC_SHORT       3'h2
`define SLPA_CYC_LONG        3'h4

// Reset values
`define SLPA_RST_RESULT      36'h0_0000_0000
`define SLPA_RST_WORD        16'h0000

`endif

/* slpa_alu.v */
/*
 Shift, logic and pointer datapath of a 16-bit signal-processor core.
 Assumes the decoder presents op and operands with a one-cycle start pulse
 and holds nothing afterwards; the register files write back the results
 when done_out is high.
*/
// Notes on behaviour
// - AND, OR, XOR on 16 bits, 2 cycles
// - Immediate forms combine 16-bit immediate with operand
// - Accumulator arithmetic left shift moves whole register
// - Plain register arithmetic left equals logical left
// - Variable left shift by four low count bits
// - Arithmetic right one bit keeps sign, 2 cycles
// - Variable arithmetic right shift, sign filled
// - Arithmetic shifted word added into accumulator
// - Logical left one bit, zero into bottom
// - Logical right one bit, zero into top
// - Variable logical right; accumulator extension zero filled
// - Logical shifted word added into accumulator
// - Left rotate through carry, one position
// - Right rotate through carry, one position
// - One normalization step, pointer zero counts
// - Pointer post-increment adds one
// - Pointer post-decrement subtracts one
// - Index register added into pointer
// - Pointer two plus unsigned 6-bit offset
// - Stack pointer minus unsigned 6-bit offset
// - Pointer plus signed 16-bit offset, 4 cycles
// - Test pointer, then decrement it
`timescale 1ns/1ps
`include "slpa_alu_regs.vh"

module slpa_alu #(
	parameter CYC_SHORT = `SLPA_CYC_SHORT,
	parameter CYC_LONG  = `SLPA_CYC_LONG
) (
	// Clock, reset, enable
	input  wire        clk_in,
	input  wire        rst_in,
	input  wire        ce_in,
	// Request from decoder
	input  wire        start_in,
	input  wire [4:0]  op_in,
	input  wire        dest_is_acc_in,
	input  wire [15:0] src_in,
	input  wire [15:0] count_src_in,
	input  wire [35:0] dest_in,
	input  wire [15:0] imm_in,
	input  wire        carry_in,
	input  wire [15:0] ptr_in,
	input  wire [15:0] index_in,
	// Results to register files
	output reg  [35:0] result_out,
	output reg  [15:0] ptr_result_out,
	output reg         carry_out,
	output reg         zero_out,
	output reg         neg_out,
	output reg         busy_out,
	output reg         done_out
);

	reg  [2:0]  remain;
	reg  [35:0] next_result;
	reg  [15:0] next_ptr;
	reg  [15:0] test_word;
	reg         next_carry;
	reg  [2:0]  next_cycles;
	reg  [15:0] word;
	reg  [15:0] vshift;
	reg  [3:0]  cnt;
	reg  [31:0] acc_shift;
	reg         leading_bit_align_step_right;
	reg         leading_bit_align_step_left;

	// Word operand: high portion of accumulator or plain register
	function [15:0] word_of;
		input        is_acc;
		input [35:0] d;
		begin
			word_of = is_acc ? d[`SLPA_MSP_MSB:`SLPA_MSP_LSB] : d[15:0];
		end
	endfunction

	// Write word back, leaving other accumulator portions untouched
	function [35:0] put_word;
		input        is_acc;
		input [35:0] d;
		input [15:0] w;
		begin
			put_word = is_acc ? {d[`SLPA_EXT_MSB:`SLPA_EXT_LSB], w, d[15:0]} : {20'h0_0000, w};
		end
	endfunction

	// Whole-accumulator load of a word with chosen extension fill
	function [35:0] fill_word;
		input        is_acc;
		input        fill;
		input [15:0] w;
		begin
			fill_word = is_acc ? {{4{fill}}, w, 16'h0000} : {20'h0_0000, w};
		end
	endfunction

	// Pointer one step up or down
	function [15:0] step_ptr;
		input        up;
		input [15:0] p;
		begin
			step_ptr = up ? p + 16'h0001 : p - 16'h0001;
		end
	endfunction

	// Whole accumulator one bit left, zero into bottom
	function [35:0] acc_shl;
		input [35:0] d;
		begin
			acc_shl = {d[34:0], 1'b0};
		end
	endfunction

	// Whole accumulator one bit right, sign kept
	function [35:0] acc_ashr;
		input [35:0] d;
		begin
			acc_ashr = {d[35], d[35:1]};
		end
	endfunction

	// Word one bit left, zero into bottom
	function [15:0] word_shl;
		input [15:0] w;
		begin
			word_shl = {w[14:0], 1'b0};
		end
	endfunction

	always @* begin
		word        = word_of(dest_is_acc_in, dest_in);
		cnt         = count_src_in[`SLPA_CNT_MSB:0];
		vshift      = `SLPA_RST_WORD;
		acc_shift   = 32'h0000_0000;
		next_result = dest_in;
		next_ptr    = ptr_in;
		next_carry  = carry_in;
		next_cycles = CYC_SHORT;
		test_word   = word;
		leading_bit_align_step_right  = ~((&dest_in[35:31]) | ~(|dest_in[35:31]));
		leading_bit_align_step_left   = ~leading_bit_align_step_right & (dest_in[31] == dest_in[30]) & (|dest_in);
		case (op_in)
			`SLPA_OP_AND: begin
				next_result = put_word(dest_is_acc_in, dest_in, src_in & word);
			end
			`SLPA_OP_OR: begin
				next_result = put_word(dest_is_acc_in, dest_in, src_in | word);
			end
			`SLPA_OP_XOR: begin
				next_result = put_word(dest_is_acc_in, dest_in, src_in ^ word);
			end
			`SLPA_OP_INVERT: begin
				next_result = put_word(dest_is_acc_in, dest_in, ~word);
			end
			`SLPA_OP_AND_IMM: begin
				next_result = put_word(dest_is_acc_in, dest_in, imm_in & word);
			end
			`SLPA_OP_OR_IMM: begin
				next_result = put_word(dest_is_acc_in, dest_in, imm_in | word);
			end
			`SLPA_OP_XOR_IMM: begin
				next_result = put_word(dest_is_acc_in, dest_in, imm_in ^ word);
			end
			`SLPA_OP_ASHL_ONE: begin
				if (dest_is_acc_in) begin
					next_result = acc_shl(dest_in);
					next_carry  = dest_in[35];
				end else begin
					next_result = put_word(1'b0, dest_in, word_shl(word));
					next_carry  = word[15];
				end
			end
			`SLPA_OP_ASHL_VAR, `SLPA_OP_LSHL_VAR: begin
				vshift      = src_in << cnt;
				next_result = fill_word(dest_is_acc_in, vshift[15], vshift);
			end
			`SLPA_OP_ASHR_ONE: begin
				if (dest_is_acc_in) begin
					next_result = acc_ashr(dest_in);
				end else begin
					next_result = put_word(1'b0, dest_in, {word[15], word[15:1]});
				end
				next_carry = dest_is_acc_in ? dest_in[0] : word[0];
			end
			`SLPA_OP_ASHR_VAR: begin
				vshift      = $signed(src_in) >>> cnt;
				next_result = fill_word(dest_is_acc_in, vshift[15], vshift);
			end
			`SLPA_OP_LSHR_VAR: begin
				vshift      = src_in >> cnt;
				next_result = fill_word(dest_is_acc_in, 1'b0, vshift);
			end
			`SLPA_OP_ASHR_ACC: begin
				acc_shift   = $signed({src_in, 16'h0000}) >>> cnt;
				next_result = dest_in + {{4{acc_shift[31]}}, acc_shift};
			end
			`SLPA_OP_LSHR_ACC: begin
				acc_shift   = {src_in, 16'h0000} >> cnt;
				next_result = dest_in + {4'h0, acc_shift};
			end
			`SLPA_OP_LSHL_ONE: begin
				next_result = put_word(dest_is_acc_in, dest_in, word_shl(word));
				next_carry  = word[15];
			end
			`SLPA_OP_LSHR_ONE: begin
				next_result = put_word(dest_is_acc_in, dest_in, {1'b0, word[15:1]});
				next_carry  = word[0];
			end
			`SLPA_OP_ROL_CARRY: begin
				next_result = put_word(dest_is_acc_in, dest_in, {word[14:0], carry_in});
				next_carry  = word[15];
			end
			`SLPA_OP_ROR_CARRY: begin
				next_result = put_word(dest_is_acc_in, dest_in, {carry_in, word[15:1]});
				next_carry  = word[0];
			end
			`SLPA_OP_ALIGN_STEP: begin
				// Extension in use: move right; redundant sign: move left
				if (leading_bit_align_step_right) begin
					next_result = acc_ashr(dest_in);
					next_ptr    = step_ptr(1'b1, ptr_in);
				end else if (leading_bit_align_step_left) begin
					next_result = acc_shl(dest_in);
					next_ptr    = step_ptr(1'b0, ptr_in);
				end
				test_word = next_result[`SLPA_MSP_MSB:`SLPA_MSP_LSB];
			end
			`SLPA_OP_PTR_INC: begin
				next_ptr = step_ptr(1'b1, ptr_in);
			end
			`SLPA_OP_PTR_DEC: begin
				next_ptr = step_ptr(1'b0, ptr_in);
			end
			`SLPA_OP_PTR_INDEX: begin
				next_ptr = ptr_in + index_in;
			end
			`SLPA_OP_PTR_TWO_OFS: begin
				next_ptr = ptr_in + {10'h000, imm_in[`SLPA_OFS6_MSB:0]};
			end
			`SLPA_OP_PTR_SP_ADJ: begin
				next_ptr = ptr_in - {10'h000, imm_in[`SLPA_OFS6_MSB:0]};
			end
			`SLPA_OP_PTR_LONG_OFS: begin
				next_ptr    = ptr_in + imm_in;
				next_cycles = CYC_LONG;
			end
			`SLPA_OP_TEST_DEC: begin
				test_word = ptr_in;
				next_ptr  = step_ptr(1'b0, ptr_in);
			end
			default: begin
				next_result = dest_in;
			end
		endcase
		if (op_in != `SLPA_OP_ALIGN_STEP && op_in != `SLPA_OP_TEST_DEC) begin
			test_word = word_of(dest_is_acc_in, next_result);
		end
	end

	// Results are latched at start; done marks the last cycle
	always @(posedge clk_in) begin
		if (rst_in) begin
			result_out     <= `SLPA_RST_RESULT;
			ptr_result_out <= `SLPA_RST_WORD;
			carry_out      <= 1'b0;
			zero_out       <= 1'b0;
			neg_out        <= 1'b0;
			busy_out       <= 1'b0;
			done_out       <= 1'b0;
			remain         <= 3'h0;
		end else if (ce_in) begin
			done_out <= 1'b0;
			if (!busy_out && start_in) begin
				result_out     <= next_result;
				ptr_result_out <= next_ptr;
				carry_out      <= next_carry;
				zero_out       <= ~(|test_word);
				neg_out        <= test_word[15];
				busy_out       <= 1'b1;
				remain         <= next_cycles - 3'h1;
			end else if (busy_out) begin
				remain <= remain - 3'h1;
				if (remain == 3'h1) begin
					busy_out <= 1'b0;
					done_out <= 1'b1;
				end
			end
		end
	end

endmodule

/* slpa_regfile_model.sv */
/*
 Register file stand-in on the far side: takes each write-back.
 Assumes done marks the one cycle in which results are valid to store.
*/
`timescale 1ns/1ps

module slpa_regfile_model (
	// Clock and write strobe
	input  wire        clk_in,
	input  wire        done_in,
	// Result bus
	input  wire [35:0] result_in,
	// Stored state
	output reg  [35:0] acc_out,
	output integer     wb_count_out
);
	initial wb_count_out = 0;

	always @(posedge clk_in) begin
		if (done_in) begin
			acc_out <= result_in;
			wb_count_out <= wb_count_out + 1;
		end
	end
endmodule

/* slpa_alu_monitor.sv */
/*
 Port assertions for the shift, logic and pointer datapath.
 Assumes binding to slpa_alu and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "slpa_alu_regs.vh"

module slpa_alu_monitor (
	// Clock and control
	input wire        clk_in,
	input wire        rst_in,
	input wire        ce_in,
	input wire        start_in,
	input wire [4:0]  op_in,
	input wire        dest_is_acc_in,
	// Operands
	input wire [15:0] src_in,
	input wire [35:0] dest_in,
	input wire [15:0] imm_in,
	input wire        carry_in,
	input wire [15:0] ptr_in,
	// Results
	input wire [35:0] result_out,
	input wire [15:0] ptr_result_out,
	input wire        carry_out,
	input wire        busy_out,
	input wire        done_out
);
	default clocking mon_cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	sequence take_s;
		ce_in && start_in && !busy_out;
	endsequence

	short_done_a: assert property (take_s ##0 op_in != `SLPA_OP_PTR_LONG_OFS ##1 ce_in |=> done_out)
		else $error("short operation not done after two cycles");
	long_done_a: assert property (take_s ##0 op_in == `SLPA_OP_PTR_LONG_OFS ##1 ce_in[*3] |=> done_out)
		else $error("long offset not done after four cycles");
	long_busy_a: assert property (take_s ##0 op_in == `SLPA_OP_PTR_LONG_OFS |=> busy_out[*3])
		else $error("long offset dropped busy early");
	done_pulse_a: assert property (done_out && ce_in |=> !done_out)
		else $error("done longer than one cycle");
	and_word_a: assert property (take_s ##0 op_in == `SLPA_OP_AND && !dest_is_acc_in |=>
		result_out[15:0] == $past(src_in & dest_in[15:0])) else $error("and result wrong");
	rol_carry_a: assert property (take_s ##0 op_in == `SLPA_OP_ROL_CARRY && !dest_is_acc_in |=>
		{carry_out, result_out[15:0]} == $past({dest_in[15:0], carry_in})) else $error("rotate wrong");
	ptr_inc_a: assert property (take_s ##0 op_in == `SLPA_OP_PTR_INC |=>
		ptr_result_out == $past(ptr_in) + 16'h0001) else $error("increment wrong");
	ptr_long_a: assert property (take_s ##0 op_in == `SLPA_OP_PTR_LONG_OFS |=>
		ptr_result_out == $past(ptr_in + imm_in)) else $error("long offset wrong");
endmodule

bind slpa_alu slpa_alu_monitor i_mon (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .start_in(start_in),
	.op_in(op_in), .dest_is_acc_in(dest_is_acc_in), .src_in(src_in), .dest_in(dest_in), .imm_in(imm_in),
	.carry_in(carry_in), .ptr_in(ptr_in), .result_out(result_out), .ptr_result_out(ptr_result_out),
	.carry_out(carry_out), .busy_out(busy_out), .done_out(done_out));

/* tb_top.sv */
/*
 Self-checking bench for the shift, logic and pointer datapath.
 Assumes slpa_alu, its header, the monitor and the register file model.
*/
`timescale 1ns/1ps
`include "slpa_alu_regs.vh"

module tb_top;
	reg         clk_in = 1'b0;
	reg         rst_in = 1'b1;
	reg         st     = 1'b0;
	reg         acc    = 1'b0;
	reg         cy     = 1'b0;
	reg         ce     = 1'b1;
	reg  [4:0]  op     = 5'h00;
	reg  [15:0] src    = 16'h0000;
	reg  [15:0] cnt    = 16'h0000;
	reg  [15:0] imm    = 16'h0000;
	reg  [15:0] ptr    = 16'h0000;
	reg  [35:0] dst    = 36'h0_0000_0000;
	wire [35:0] res;
	wire [35:0] wb;
	wire [15:0] pres;
	wire        cyo;
	wire        zro;
	wire        done;
	wire        busy;
	wire        neg;
	integer     wbn;
	integer     fail_count  = 0;
	integer     comparisons = 0;
	integer     ops         = 0;
	integer     i;

	slpa_alu i_dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .start_in(st), .op_in(op),
		.dest_is_acc_in(acc), .src_in(src), .count_src_in(cnt), .dest_in(dst), .imm_in(imm),
		.carry_in(cy), .ptr_in(ptr), .index_in(cnt), .result_out(res), .ptr_result_out(pres),
		.carry_out(cyo), .zero_out(zro), .neg_out(neg), .busy_out(busy), .done_out(done));
	slpa_regfile_model i_model (.clk_in(clk_in), .done_in(done), .result_in(res), .acc_out(wb),
		.wb_count_out(wbn));

	task chk(input [35:0] seen, input [35:0] exp);
		begin
			comparisons = comparisons + 1;
			if (seen !== exp) begin
				fail_count = fail_count + 1;
				$display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
			end
		end
	endtask

	task end_sim;
		begin
			$display("checks %0d, mismatches %0d", comparisons, fail_count);
			if (fail_count == 0 && comparisons > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask

	// One request, then count edges up to done
	task run(input [4:0] o, input a, input [15:0] s, c, input [35:0] d, input [15:0] im, input ci, input [15:0] p);
		integer t;
		begin
			@(posedge clk_in);
			op <= o;
			acc <= a;
			src <= s;
			cnt <= c;
			dst <= d;
			imm <= im;
			cy <= ci;
			ptr <= p;
			st <= 1'b1;
			t = 0;
			do begin
				@(posedge clk_in);
				st <= 1'b0;
				#1;
				t = t + 1;
			end while (done !== 1'b1 && t < 9);
			ops = ops + 1;
			chk(t, (o == `SLPA_OP_PTR_LONG_OFS) ? 4 : 2);
		end
	endtask

	task dt(input [4:0] o, input a, input [15:0] s, c, input [35:0] d, input ci, input [35:0] er, input ec);
		begin
			run(o, a, s, c, d, 16'h0FF0, ci, 16'h0000);
			chk(res, er);
			chk(cyo, ec);
			chk(neg, a ? er[31] : er[15]);
			chk(zro, (a ? er[31:16] : er[15:0]) == 16'h0000);
		end
	endtask

	task pt(input [4:0] o, input [15:0] p, im, ep);
		begin
			run(o, 1'b0, 16'h0000, im, 36'h0_0000_0000, im, 1'b0, p);
			chk(pres, ep);
		end
	endtask

	// Word results of the logic group for F0F0 with 3C3C, immediate 0FF0
	function [35:0] lexp(input integer k);
		case (k)
			0: lexp = 36'h3030;
			1: lexp = 36'hFCFC;
			2: lexp = 36'hCCCC;
			3: lexp = 36'hC3C3;
			4: lexp = 36'h0C30;
			5: lexp = 36'h3FFC;
			default: lexp = 36'h33CC;
		endcase
	endfunction

	initial begin
		forever #12.5 clk_in = ~clk_in;
	end

	initial begin
		#100000;
		fail_count = fail_count + 1;
		end_sim;
	end

	// Logic group on a register destination
	task t_logic;
		begin
			for (i = 0; i < 7; i = i + 1)
				dt(`SLPA_OP_AND + i[4:0], 1'b0, 16'hF0F0, 16'h0000, 36'h3C3C, 1'b1, lexp(i), 1'b1);
		end
	endtask

	// One-bit, variable and accumulating shifts
	task t_shifts;
		begin
			dt(`SLPA_OP_ASHL_ONE, 1'b1, 16'h0000, 16'h0000, 36'h8_0000_0001, 1'b0, 36'h0_0000_0002, 1'b1);
			dt(`SLPA_OP_ASHL_ONE, 1'b0, 16'h0000, 16'h0000, 36'hC001, 1'b0, 36'h8002, 1'b1);
			dt(`SLPA_OP_LSHL_ONE, 1'b0, 16'h0000, 16'h0000, 36'hC001, 1'b0, 36'h8002, 1'b1);
			dt(`SLPA_OP_ASHR_ONE, 1'b0, 16'h0000, 16'h0000, 36'h8002, 1'b0, 36'hC001, 1'b0);
			dt(`SLPA_OP_LSHR_ONE, 1'b0, 16'h0000, 16'h0000, 36'h8001, 1'b0, 36'h4000, 1'b1);
			dt(`SLPA_OP_ASHL_VAR, 1'b0, 16'h0003, 16'hFFF4, 36'h0000, 1'b0, 36'h0030, 1'b0);
			dt(`SLPA_OP_LSHL_VAR, 1'b0, 16'h0003, 16'hFFF4, 36'h0000, 1'b0, 36'h0030, 1'b0);
			dt(`SLPA_OP_ASHR_VAR, 1'b0, 16'h8000, 16'h0013, 36'h0000, 1'b0, 36'hF000, 1'b0);
			dt(`SLPA_OP_LSHR_VAR, 1'b1, 16'h8000, 16'h0003, 36'hF_FFFF_FFFF, 1'b0, 36'h0_1000_0000, 1'b0);
			dt(`SLPA_OP_ASHR_ACC, 1'b1, 16'h8000, 16'h0001, 36'h0_0000_0001, 1'b0, 36'hF_C000_0001, 1'b0);
			dt(`SLPA_OP_LSHR_ACC, 1'b1, 16'h8000, 16'h0001, 36'h0_0000_0001, 1'b0, 36'h0_4000_0001, 1'b0);
		end
	endtask

	// Rotates through carry and one align step
	task t_rotate_align;
		begin
			dt(`SLPA_OP_ROL_CARRY, 1'b0, 16'h0000, 16'h0000, 36'h8001, 1'b0, 36'h0002, 1'b1);
			dt(`SLPA_OP_ROR_CARRY, 1'b0, 16'h0000, 16'h0000, 36'h0001, 1'b1, 36'h8000, 1'b1);
			run(`SLPA_OP_ALIGN_STEP, 1'b1, 16'h0000, 16'h0000, 36'h0_2000_0000, 16'h0000, 1'b0, 16'h0005);
			chk(res, 36'h0_4000_0000);
			chk(pres, 16'h0004);
		end
	endtask

	// Pointer updates and test-and-decrement
	task t_pointers;
		begin
			pt(`SLPA_OP_PTR_INC, 16'h00FF, 16'h0000, 16'h0100);
			pt(`SLPA_OP_PTR_DEC, 16'h0000, 16'h0000, 16'hFFFF);
			pt(`SLPA_OP_PTR_INDEX, 16'h1000, 16'h0234, 16'h1234);
			pt(`SLPA_OP_PTR_TWO_OFS, 16'h0010, 16'hFFFF, 16'h004F);
			pt(`SLPA_OP_PTR_SP_ADJ, 16'h0040, 16'hFF01, 16'h003F);
			pt(`SLPA_OP_PTR_LONG_OFS, 16'h0003, 16'hFFFE, 16'h0001);
			pt(`SLPA_OP_TEST_DEC, 16'h0000, 16'h0000, 16'hFFFF);
			chk(zro, 1'b1);
		end
	endtask

	// Enable low freezes a running operation
	task t_stall;
		begin
			@(posedge clk_in);
			op  <= `SLPA_OP_AND;
			acc <= 1'b0;
			src <= 16'hFFFF;
			dst <= 36'h0_0000_1234;
			st  <= 1'b1;
			@(posedge clk_in);
			st <= 1'b0;
			ce <= 1'b0;
			repeat (3) @(posedge clk_in);
			ce <= 1'b1;
			#1;
			chk(busy, 1'b1);
			chk(done, 1'b0);
			@(posedge clk_in);
			#1;
			chk(done, 1'b1);
			chk(res, 36'h0_0000_1234);
			ops = ops + 1;
		end
	endtask

	// Reset in the middle of a long offset clears all outputs
	task t_reset;
		begin
			@(posedge clk_in);
			op  <= `SLPA_OP_PTR_LONG_OFS;
			ptr <= 16'h0003;
			imm <= 16'hFFFE;
			st  <= 1'b1;
			@(posedge clk_in);
			st     <= 1'b0;
			rst_in <= 1'b1;
			@(posedge clk_in);
			rst_in <= 1'b0;
			#1;
			chk(res, 36'h0_0000_0000);
			chk(pres, 16'h0000);
			chk({cyo, zro, neg, busy, done}, 5'h00);
			@(posedge clk_in);
			#1;
			chk(busy, 1'b0);
			chk(done, 1'b0);
		end
	endtask

	initial begin
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
		t_logic;
		t_shifts;
		t_rotate_align;
		t_pointers;
		t_stall;
		t_reset;
		@(posedge clk_in);
		#1;
		chk(wbn, ops);
		chk(wb, 36'h0_0000_1234);
		end_sim;
	end
endmodule
